// ===== epd_divider.sv
// Encoder pulse divider: divides quadrature A/B, passes index Z.
// Assumes encoder pins are asynchronous and APB runs on clk.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns

// Contract
// R1: Switch closed reads as zero, open reads as one.
// R2: Switch one is reserved and ignored by the divider.
// R3: Switches five to twelve form divisor, switch five least significant.
// R4: Any divisor one to 256 divides pulse rate by n.
// R5: Switch two picks input type, switch three output type.
// R6: Both types zero: both outputs carry divided A and B.
// R7: Input zero, output one: A divided, B shows phase order.
// R8: Input type one: source drives square A and direction on B.
// R9: Direction mode: B low means A leads, A output divided.
// R10: Direction mode: B output follows B input, undivided.
// R11: Index output follows index input in every mode.
// R12: Switch four clears the internal pulse counters.
// R13: Operator clears the counter after changing divisor or types.
// R14: Operator returns clear switch to one to resume counting.
// R15: Clear active at zero; counters held while zero.
// R16: All-zero divisor field means division by 256.
module epd_divider
    import epd_pkg::*;
(
    input wire logic clk,                     // 10 MHz clock
    input wire logic rstn,                    // Synchronous reset, low
    input wire logic psel,                    // APB select
    input wire logic penable,                 // APB access phase
    input wire logic pwrite,                  // APB write
    input wire logic [EPD_ADDR_W-1:0] paddr,  // APB byte address
    input wire logic [31:0] pwdata,           // APB write data
    input wire logic [3:0] pstrb,             // APB byte strobes
    output logic [31:0] prdata,               // APB read data
    output logic pready,                      // APB ready
    output logic pslverr,                     // APB error, unmapped
    input wire epd_enc_t encIn,               // Encoder pins A, B, Z
    output epd_enc_t encOut                   // Divided pins A, B, passed index Z
);

    // ************************************************************
    // State
    // ************************************************************
    epd_state_t state_ff;
    epd_state_t nxt_state;
    epd_mode_t mode;
    logic clearN;
    logic [EPD_DIV_W-1:0] divField;
    logic [EPD_CNT_W-1:0] termCnt;
    logic [EPD_NCH-1:0] edgeSeen;
    logic setupPh;
    logic accessWr;
    logic addrOk;

    // Decoded switch fields; switch one never read
    assign mode = epd_mode_t'({state_ff.sw[EPD_SW_IN_TYPE],
                              state_ff.sw[EPD_SW_OUT_TYPE]}); // [R5] [R2]
    assign clearN = state_ff.sw[EPD_SW_CLEAR_N];               // [R15]
    assign divField = state_ff.sw[EPD_SW_DIV_MSB:EPD_SW_DIV_LSB]; // [R3]

    // Terminal count n-1, zero field stands for 256
    always_comb begin
        if (divField == '0) begin
            termCnt = EPD_DIV_FULL_M1;                           // [R16]
        end else begin
            termCnt = {1'b0, divField} - EPD_CNT_ONE;            // [R4]
        end
    end

    // Bus phase decode
    assign setupPh = psel && !penable;
    assign accessWr = psel && penable && pwrite && !state_ff.err;
    assign addrOk = (paddr == EPD_OFS_SWITCH) || (paddr == EPD_OFS_STATUS);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        edgeSeen = '0;

        // Two-flop synchronisers, then edge history
        nxt_state.sync1 = {encIn.a, encIn.b, encIn.z};
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.prev = state_ff.sync2;

        // Per-channel edge counters, toggle every n edges
        for (int ch = 0; ch < EPD_NCH; ch++) begin
            edgeSeen[ch] = state_ff.sync2[2-ch] ^ state_ff.prev[2-ch];
            if (!clearN) begin
                nxt_state.cnt[ch] = '0;                          // [R12] [R15]
                nxt_state.div[ch] = 1'b0;
            end else if (edgeSeen[ch]) begin
                if (state_ff.cnt[ch] >= termCnt) begin
                    nxt_state.cnt[ch] = '0;
                    nxt_state.div[ch] = !state_ff.div[ch];       // [R4]
                end else begin
                    nxt_state.cnt[ch] = state_ff.cnt[ch] + EPD_CNT_ONE;
                end
            end
        end

        // Phase order: B level at rising A; low means A leads
        if (!clearN) begin
            nxt_state.dir = 1'b0;
        end else if (mode == EPD_MODE_PHASE) begin
            if (state_ff.sync2[2] && !state_ff.prev[2]) begin
                nxt_state.dir = state_ff.sync2[1];               // [R7]
            end
        end else begin
            nxt_state.dir = state_ff.sync2[1];                   // [R9]
        end

        // B output by mode
        unique case (mode)
            EPD_MODE_QUAD: nxt_state.bOut = nxt_state.div[EPD_CH_B];     // [R6]
            EPD_MODE_PHASE: nxt_state.bOut = nxt_state.dir;              // [R7]
            EPD_MODE_DIRIN0: nxt_state.bOut = state_ff.sync2[1];         // [R10] [R8]
            EPD_MODE_DIRIN1: nxt_state.bOut = state_ff.sync2[1];         // [R10] [R8]
        endcase

        // Index passes straight through
        nxt_state.zOut = state_ff.sync2[0];                      // [R11]

        // APB setup: capture read data and error
        if (setupPh) begin
            nxt_state.err = !addrOk;
            nxt_state.rdata = EPD_RDATA_ZERO;
            if (paddr == EPD_OFS_SWITCH) begin
                nxt_state.rdata[EPD_SW_W-1:0] = state_ff.sw;
            end else if (paddr == EPD_OFS_STATUS) begin
                nxt_state.rdata[EPD_ST_A] = state_ff.div[EPD_CH_A];
                nxt_state.rdata[EPD_ST_B] = state_ff.bOut;
                nxt_state.rdata[EPD_ST_Z] = state_ff.zOut;
                nxt_state.rdata[EPD_ST_DIR] = state_ff.dir;
                nxt_state.rdata[EPD_ST_CNT_MSB:EPD_ST_CNT_LSB] = state_ff.cnt[EPD_CH_A];
            end
        end

        // APB access: switch image write, closed switch is zero
        if (accessWr && (paddr == EPD_OFS_SWITCH)) begin
            if (pstrb[0]) begin
                nxt_state.sw[7:0] = pwdata[7:0];                 // [R1]
            end
            if (pstrb[1]) begin
                nxt_state.sw[EPD_SW_W-1:8] = pwdata[EPD_SW_W-1:8]; // [R1]
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= EPD_STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs
    assign encOut.a = state_ff.div[EPD_CH_A];                    // [R6] [R9]
    assign encOut.b = state_ff.bOut;
    assign encOut.z = state_ff.zOut;
    assign prdata = state_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && state_ff.err;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic zOutPast;
    assign zOutPast = encOut.z;

    property p_index_pass;
        @(posedge clk) disable iff (!rstn)
        $past(rstn, 3) |-> (zOutPast == $past(encIn.z, 3));
    endproperty
    a_index_pass: assert property (p_index_pass) // [R11]
        else $error("Index output does not follow index input");

    property p_clear_holds;
        @(posedge clk) disable iff (!rstn)
        !clearN |=> (state_ff.cnt == '0) && !encOut.a;
    endproperty
    a_clear_holds: assert property (p_clear_holds) // [R12]
        else $error("Counter not held cleared while clear is low");

    property p_clear_level;
        @(posedge clk) disable iff (!rstn)
        (!clearN)[*2] |-> (state_ff.div == '0) && (state_ff.cnt[EPD_CH_B] == '0);
    endproperty
    a_clear_level: assert property (p_clear_level) // [R15]
        else $error("Divider moved while clear stayed low");

    property p_terminal_toggle;
        @(posedge clk) disable iff (!rstn)
        (clearN && edgeSeen[EPD_CH_A] && state_ff.cnt[EPD_CH_A] == termCnt)
            |=> (encOut.a != $past(encOut.a)) && (state_ff.cnt[EPD_CH_A] == '0);
    endproperty
    a_terminal_toggle: assert property (p_terminal_toggle) // [R4]
        else $error("A output did not toggle at terminal count");

    property p_no_early_toggle;
        @(posedge clk) disable iff (!rstn)
        (clearN && state_ff.cnt[EPD_CH_A] < termCnt) |=> $stable(encOut.a) || !$past(clearN);
    endproperty
    a_no_early_toggle: assert property (p_no_early_toggle) // [R4]
        else $error("A output toggled before terminal count");

    property p_full_divisor;
        @(posedge clk) disable iff (!rstn)
        (divField == '0) |-> (termCnt == EPD_DIV_FULL_M1);
    endproperty
    a_full_divisor: assert property (p_full_divisor) // [R16]
        else $error("Zero divisor field not taken as 256");

    property p_dirin_follow;
        @(posedge clk) disable iff (!rstn)
        (state_ff.sw[EPD_SW_IN_TYPE] && $past(state_ff.sw[EPD_SW_IN_TYPE], 3))
            |-> (encOut.b == $past(encIn.b, 3));
    endproperty
    a_dirin_follow: assert property (p_dirin_follow) // [R10]
        else $error("B output does not follow direction input");

    property p_phase_order;
        @(posedge clk) disable iff (!rstn)
        (clearN && mode == EPD_MODE_PHASE && state_ff.sync2[2] && !state_ff.prev[2])
            ##1 (mode == EPD_MODE_PHASE) |-> (encOut.b == $past(state_ff.sync2[1]));
    endproperty
    a_phase_order: assert property (p_phase_order) // [R7]
        else $error("B output does not show phase order");

    property p_quad_b;
        @(posedge clk) disable iff (!rstn)
        (mode == EPD_MODE_QUAD) |=> (encOut.b == state_ff.div[EPD_CH_B]);
    endproperty
    a_quad_b: assert property (p_quad_b) // [R6]
        else $error("B output is not divided B in quadrature mode");

    property p_unmapped_err;
        @(posedge clk) disable iff (!rstn)
        (psel && !penable && !addrOk) ##1 (psel && penable) |-> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) // APB access, our own choice
        else $error("Unmapped address gave no error");

    // ************************************************************
    // Datapath and bus assertions
    // ************************************************************
    property p_count_step;
        @(posedge clk) disable iff (!rstn)
        (clearN && edgeSeen[EPD_CH_A] && state_ff.cnt[EPD_CH_A] < termCnt)
            |=> (state_ff.cnt[EPD_CH_A] == $past(state_ff.cnt[EPD_CH_A]) + EPD_CNT_ONE);
    endproperty
    a_count_step: assert property (p_count_step) // [R4]
        else $error("A counter did not step on an input edge");

    property p_count_hold;
        @(posedge clk) disable iff (!rstn)
        (clearN && !edgeSeen[EPD_CH_A])
            |=> $stable(state_ff.cnt[EPD_CH_A]) && $stable(encOut.a);
    endproperty
    a_count_hold: assert property (p_count_hold) // [R4]
        else $error("A counter moved without an input edge");

    property p_b_toggle;
        @(posedge clk) disable iff (!rstn)
        (clearN && edgeSeen[EPD_CH_B] && state_ff.cnt[EPD_CH_B] >= termCnt)
            |=> (state_ff.div[EPD_CH_B] != $past(state_ff.div[EPD_CH_B]))
                && (state_ff.cnt[EPD_CH_B] == '0);
    endproperty
    a_b_toggle: assert property (p_b_toggle) // [R6]
        else $error("Divided B did not toggle at terminal count");

    property p_full_no_early;
        @(posedge clk) disable iff (!rstn)
        (clearN && divField == '0 && edgeSeen[EPD_CH_A]
            && state_ff.cnt[EPD_CH_A] == EPD_DIV_FULL_M1 - EPD_CNT_ONE)
            |=> $stable(encOut.a) && (state_ff.cnt[EPD_CH_A] == EPD_DIV_FULL_M1);
    endproperty
    a_full_no_early: assert property (p_full_no_early) // [R16]
        else $error("Zero divisor field toggled before edge 256");

    property p_phase_hold;
        @(posedge clk) disable iff (!rstn)
        (clearN && mode == EPD_MODE_PHASE && !(state_ff.sync2[2] && !state_ff.prev[2]))
            |=> $stable(state_ff.dir);
    endproperty
    a_phase_hold: assert property (p_phase_hold) // [R7]
        else $error("Phase order changed without a rising A");

    property p_phase_drive;
        @(posedge clk) disable iff (!rstn)
        (mode == EPD_MODE_PHASE) |=> (encOut.b == state_ff.dir);
    endproperty
    a_phase_drive: assert property (p_phase_drive) // [R7]
        else $error("B output is not phase order in phase mode");

    property p_phase_clear;
        @(posedge clk) disable iff (!rstn)
        (!clearN && mode == EPD_MODE_PHASE)[*2] |-> !encOut.b && !state_ff.dir;
    endproperty
    a_phase_clear: assert property (p_phase_clear) // [R15]
        else $error("Phase order not held cleared");

    property p_dirin_dir;
        @(posedge clk) disable iff (!rstn)
        (clearN && state_ff.sw[EPD_SW_IN_TYPE]) |=> (state_ff.dir == $past(state_ff.sync2[1]));
    endproperty
    a_dirin_dir: assert property (p_dirin_dir) // [R9]
        else $error("Direction does not track B input");

    property p_dirin_clear;
        @(posedge clk) disable iff (!rstn)
        (!clearN && state_ff.sw[EPD_SW_IN_TYPE]) |=> (encOut.b == $past(state_ff.sync2[1]));
    endproperty
    a_dirin_clear: assert property (p_dirin_clear) // [R10]
        else $error("B output stopped following input during clear");

    property p_index_clear;
        @(posedge clk) disable iff (!rstn)
        !clearN |=> (encOut.z == $past(state_ff.sync2[0]));
    endproperty
    a_index_clear: assert property (p_index_clear) // [R11]
        else $error("Index output held by clear");

    property p_rdata_switch;
        @(posedge clk) disable iff (!rstn)
        (psel && !penable && paddr == EPD_OFS_SWITCH)
            |=> (prdata[EPD_SW_W-1:0] == $past(state_ff.sw)) && (prdata[31:EPD_SW_W] == '0);
    endproperty
    a_rdata_switch: assert property (p_rdata_switch) // [R1]
        else $error("Switch read data does not match switch levels");

    property p_sw_write_low;
        @(posedge clk) disable iff (!rstn)
        (accessWr && paddr == EPD_OFS_SWITCH && pstrb[0])
            |=> (state_ff.sw[7:0] == $past(pwdata[7:0]));
    endproperty
    a_sw_write_low: assert property (p_sw_write_low) // [R1]
        else $error("Low switch byte not written");

endmodule : epd_divider

// ===== epd_pkg.sv
// Shared constants and types for the encoder pulse divider.
// Assumes a single 10 MHz clock and an APB register port.
package epd_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int EPD_ADDR_W = 8;
    localparam logic [EPD_ADDR_W-1:0] EPD_OFS_SWITCH = 8'h00; // Switch bank image
    localparam logic [EPD_ADDR_W-1:0] EPD_OFS_STATUS = 8'h04; // Divider state

    // ************************************************************
    // Switch bank layout (bit k holds switch k+1)
    // ************************************************************
    localparam int EPD_SW_W = 12;
    localparam int EPD_SW_RESERVED = 0;  // Switch 1, no function
    localparam int EPD_SW_IN_TYPE = 1;   // Switch 2
    localparam int EPD_SW_OUT_TYPE = 2;  // Switch 3
    localparam int EPD_SW_CLEAR_N = 3;   // Switch 4, clear when zero
    localparam int EPD_SW_DIV_LSB = 4;   // Switch 5
    localparam int EPD_SW_DIV_MSB = 11;  // Switch 12
    localparam int EPD_DIV_W = 8;
    localparam int EPD_CNT_W = 9;
    localparam logic [EPD_SW_W-1:0] EPD_SW_RST = 12'hFFF;     // All switches open
    localparam logic [EPD_CNT_W-1:0] EPD_DIV_FULL_M1 = 9'h0FF; // Zero field means 256
    localparam logic [EPD_CNT_W-1:0] EPD_CNT_ONE = 9'h001;

    // ************************************************************
    // Status register layout
    // ************************************************************
    localparam int EPD_ST_A = 0;
    localparam int EPD_ST_B = 1;
    localparam int EPD_ST_Z = 2;
    localparam int EPD_ST_DIR = 3;
    localparam int EPD_ST_CNT_LSB = 8;
    localparam int EPD_ST_CNT_MSB = 16;
    localparam logic [31:0] EPD_RDATA_ZERO = 32'h0000_0000;

    // ************************************************************
    // Channel indices and channel count
    // ************************************************************
    localparam int EPD_CH_A = 0;
    localparam int EPD_CH_B = 1;
    localparam int EPD_CH_Z = 2;
    localparam int EPD_NCH = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        EPD_MODE_QUAD = 2'b00,   // Divided A and B
        EPD_MODE_PHASE = 2'b01,  // Divided A, phase order on B
        EPD_MODE_DIRIN0 = 2'b10, // Direction level on B input
        EPD_MODE_DIRIN1 = 2'b11  // Same, output type ignored
    } epd_mode_t;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } epd_enc_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prev;
        logic [EPD_NCH-1:0][EPD_CNT_W-1:0] cnt;
        logic [EPD_NCH-1:0] div;
        logic bOut;
        logic zOut;
        logic dir;
        logic [EPD_SW_W-1:0] sw;
        logic [31:0] rdata;
        logic err;
    } epd_state_t;

    localparam epd_state_t EPD_STATE_RST = '{
        sync1: 3'h0, sync2: 3'h0, prev: 3'h0, cnt: '0, div: 2'h0,
        bOut: 1'b0, zOut: 1'b0, dir: 1'b0, sw: EPD_SW_RST,
        rdata: EPD_RDATA_ZERO, err: 1'b0
    };

endpackage : epd_pkg

// ===== epd_enc_model.sv
// Partner model: incremental encoder on the pins, edge counter behind.
// Assumes the bench calls its tasks just after a rising clk edge.
`timescale 1ns/1ns
module epd_enc_model
    import epd_pkg::*;
(
    input wire logic clk,       // Bench clock
    output epd_enc_t encIn,     // Encoder pins into the divider
    input wire epd_enc_t encOut // Divided pins back from the divider
);
    int aEdges = 0;
    int bEdges = 0;
    logic prevA = 1'b0;
    logic prevB = 1'b0;

    // ************************************************************
    // Pin drive
    // ************************************************************
    initial begin
        encIn = '0;
    end

    // Each level stands two clocks so the synchroniser sees it
    task automatic hold2(input logic a, input logic b);
        encIn.a <= a;
        encIn.b <= b;
        repeat (2) @(posedge clk);
    endtask : hold2

    // Quadrature square waves, A leads unless rev
    task automatic quad(input int p, input logic rev);
        for (int i = 0; i < p; i++) begin
            hold2(!rev, rev);
            hold2(1'b1, 1'b1);
            hold2(rev, !rev);
            hold2(1'b0, 1'b0);
        end
    endtask : quad

    // Square wave on A, direction level on B
    task automatic dirsq(input int p, input logic lvl);
        for (int i = 0; i < p; i++) begin
            hold2(1'b1, lvl);
            hold2(1'b0, lvl);
        end
    endtask : dirsq

    // Index level held long enough to pass the pipeline
    task automatic zlevel(input logic v);
        encIn.z <= v;
        repeat (5) @(posedge clk);
    endtask : zlevel

    // ************************************************************
    // Downstream counter of output edges
    // ************************************************************
    // Sampled on the falling edge, clear of the output update
    always @(negedge clk) begin
        if (encOut.a !== prevA) aEdges++;
        if (encOut.b !== prevB) bEdges++;
        prevA = encOut.a;
        prevB = encOut.b;
    end

    task automatic clr_counts();
        aEdges = 0;
        bEdges = 0;
    endtask : clr_counts
endmodule : epd_enc_model

// ===== tb_epd_divider.sv
// Testbench for the encoder pulse divider, APB master plus encoder model.
// Assumes zero wait state APB and a three clock pin latency.
`timescale 1ns/1ns
module tb_epd_divider
    import epd_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [EPD_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    epd_enc_t encIn;
    epd_enc_t encOut;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] divs [5] = '{8'h01, 8'h02, 8'h03, 8'h55, 8'h00};
    int pers [5] = '{6, 8, 9, 85, 256};

    // ************************************************************
    // Clock, design and partner
    // ************************************************************
    initial begin
        forever #50 clk = ~clk;
    end

    epd_divider i_epd_divider (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .encIn(encIn), .encOut(encOut));

    epd_enc_model i_epd_enc_model (.clk(clk), .encIn(encIn), .encOut(encOut));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk_word

    task automatic chk_count(input int got, input int exp, input string msg);
        n_checks++;
        if (got != exp) begin
            err_total++;
            $display("unexpected at %0t: %s %0d", $time, msg, got);
        end
    endtask : chk_count

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Clear with new settings, then release the clear
    task automatic setup(input logic [7:0] dv, input logic inT, input logic outT, input logic rs);
        apb(1'b1, EPD_OFS_SWITCH, {20'h0, dv, 1'b0, outT, inT, rs}, rd, er);
        apb(1'b1, EPD_OFS_SWITCH, {20'h0, dv, 1'b1, outT, inT, rs}, rd, er);
        i_epd_enc_model.clr_counts();
    endtask : setup

    task automatic settle_z();
        repeat (6) @(posedge clk);
        i_epd_enc_model.zlevel(1'b1);
        chk_bit(encOut.z, 1'b1, "index high");
        i_epd_enc_model.zlevel(1'b0);
        chk_bit(encOut.z, 1'b0, "index low");
    endtask : settle_z

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, EPD_OFS_SWITCH, 32'h0, rd, er);
        chk_word(rd, 32'h0000_0FFF, "switch reset image");
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk_bit(er, 1'b1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped data");
        apb(1'b1, EPD_OFS_STATUS, 32'hFFFF_FFFF, rd, er);
        chk_bit(er, 1'b0, "status write error");
        for (int i = 0; i < 5; i++) begin
            setup(divs[i], 1'b0, 1'b0, i != 0);
            i_epd_enc_model.quad(pers[i], 1'b0);
            settle_z();
            chk_count(i_epd_enc_model.aEdges, 2 * pers[i] / ((divs[i] == 0) ? 256 : divs[i]),
                "A toggles");
            chk_count(i_epd_enc_model.bEdges, 2 * pers[i] / ((divs[i] == 0) ? 256 : divs[i]),
                "B toggles");
        end
        setup(8'h01, 1'b0, 1'b1, 1'b1);
        i_epd_enc_model.quad(2, 1'b0);
        settle_z();
        chk_bit(encOut.b, 1'b0, "phase A leads");
        chk_count(i_epd_enc_model.aEdges, 4, "phase A toggles");
        i_epd_enc_model.quad(2, 1'b1);
        settle_z();
        chk_bit(encOut.b, 1'b1, "phase B leads");
        apb(1'b0, EPD_OFS_STATUS, 32'h0, rd, er);
        chk_word(rd, 32'h0000_000A, "status phase B leads");
        for (int m = 0; m < 4; m++) begin
            setup(8'h02, 1'b1, m[1], 1'b1);
            i_epd_enc_model.dirsq(4, m[0]);
            settle_z();
            chk_bit(encOut.b, m[0], "direction follow");
            chk_count(i_epd_enc_model.aEdges, 4, "direction A toggles");
        end
        apb(1'b1, EPD_OFS_SWITCH, 32'h0000_0011, rd, er);
        i_epd_enc_model.clr_counts();
        i_epd_enc_model.quad(4, 1'b0);
        settle_z();
        chk_count(i_epd_enc_model.aEdges, 0, "held by clear");
        chk_bit(encOut.a, 1'b0, "A held low");
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule : tb_epd_divider
